// ===== common/wwdsup_pkg.sv
// constants, encodings and state types of the window watchdog supervisor
package wwdsup_pkg;

	// counter width shared by both timers
	localparam int CNT_W = 32;

	// system clock period
	localparam int unsigned CLK_PERIOD_NS = 40;

	// nominal times in ns; preset values are plain defaults
	localparam int unsigned T_RESET_DELAY_NS = 10_000_000;
	localparam int unsigned T_PULLUP_LOWER_NS = 1_000_000;
	localparam int unsigned T_PULLUP_UPPER_NS = 10_000_000;
	localparam int unsigned T_OPEN_LOWER_NS = 2_000_000;
	localparam int unsigned T_OPEN_UPPER_NS = 20_000_000;

	// least times round up, longest times round down
	localparam logic [31:0] RST_DELAY_CYC =
		32'((T_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [31:0] PULLUP_LOWER_CYC =
		32'((T_PULLUP_LOWER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [31:0] PULLUP_UPPER_CYC =
		32'(T_PULLUP_UPPER_NS / CLK_PERIOD_NS);
	localparam logic [31:0] OPEN_LOWER_CYC =
		32'((T_OPEN_LOWER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [31:0] OPEN_UPPER_CYC =
		32'(T_OPEN_UPPER_NS / CLK_PERIOD_NS);

	// timeout-config pin encoding; 2'h3 is treated as open
	localparam logic [1:0] CFG_CAP = 2'h0;
	localparam logic [1:0] CFG_PULLUP = 2'h1;
	localparam logic [1:0] CFG_OPEN = 2'h2;

	// reset supervisor states, gray along hold, delay, run
	typedef enum logic [1:0] {
		SUP_HOLD = 2'h0,
		SUP_DELAY = 2'h1,
		SUP_RUN = 2'h3
	} wwdsup_sup_t;

	// watchdog states, gray along idle, closed, open, fault
	typedef enum logic [1:0] {
		WD_IDLE = 2'h0,
		WD_CLOSED = 2'h1,
		WD_OPEN = 2'h3,
		WD_FAULT = 2'h2
	} wwdsup_wd_t;

endpackage : wwdsup_pkg

// ===== rtl/wwdsup_timer.sv
// down-counting timer, loadable, stops at zero
`timescale 1ns/1ps

module wwdsup_timer (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [wwdsup_pkg::CNT_W-1:0] load_val,
	output logic [wwdsup_pkg::CNT_W-1:0] count
);

	typedef struct packed {
		logic [wwdsup_pkg::CNT_W-1:0] cnt;
	} wwdsup_tmr_st_t;

	wwdsup_tmr_st_t st_r;
	wwdsup_tmr_st_t st_nxt;

	// unit step at the counter's own width
	localparam logic [wwdsup_pkg::CNT_W-1:0] STEP = 1;

	// load wins, otherwise count down to zero and hold
	always_comb begin
		st_nxt = st_r;
		if (load) begin
			st_nxt.cnt = load_val;
		end else if (st_r.cnt != '0) begin
			st_nxt.cnt = st_r.cnt - STEP;
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign count = st_r.cnt;

endmodule : wwdsup_timer

// ===== rtl/wwdsup_top.sv
// reset supervisor with window watchdog
// Contract
// - manual reset low asserts system reset
// - reset held for delay after manual release
// - supply-good false asserts system reset
// - supply return starts delay, release at end
// - release needs supply good and delay done
// - strap low disables the watchdog
// - kick edge must fall inside window
// - kick ignored in reset, fault, disabled
// - timeout drives fault low for reset delay
// - fault only while reset released
// - config pin selects timeout source
`timescale 1ns/1ps

module wwdsup_top #(
	parameter logic [31:0] RST_CYC = wwdsup_pkg::RST_DELAY_CYC,
	parameter logic [31:0] PU_LOWER_CYC = wwdsup_pkg::PULLUP_LOWER_CYC,
	parameter logic [31:0] PU_UPPER_CYC = wwdsup_pkg::PULLUP_UPPER_CYC,
	parameter logic [31:0] OP_LOWER_CYC = wwdsup_pkg::OPEN_LOWER_CYC,
	parameter logic [31:0] OP_UPPER_CYC = wwdsup_pkg::OPEN_UPPER_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic supply_good,
	input wire logic manual_reset_n,
	input wire logic watchdog_kick_in,
	input wire logic watchdog_enable_strap,
	input wire logic [1:0] timeout_config_pin,
	input wire logic [31:0] cap_lower_cycles,
	input wire logic [31:0] cap_upper_cycles,
	input wire logic reset_n_i,
	output logic reset_n_o,
	output logic reset_n_oe,
	input wire logic watchdog_fault_n_i,
	output logic watchdog_fault_n_o,
	output logic watchdog_fault_n_oe
);

	typedef struct packed {
		wwdsup_pkg::wwdsup_sup_t sup;
		wwdsup_pkg::wwdsup_wd_t wd;
		logic kick_prev;
		logic rst_o;
		logic rst_oe;
		logic flt_o;
		logic flt_oe;
	} wwdsup_st_t;

	wwdsup_st_t st_r;
	wwdsup_st_t st_nxt;

	logic hold;
	logic active;
	logic kick_fall;
	logic kick_ok;
	logic rst_load;
	logic wd_load;
	logic [31:0] rst_val;
	logic [31:0] wd_val;
	logic [31:0] rst_cnt;
	logic [31:0] wd_cnt;
	logic [31:0] lower_cyc;
	logic [31:0] upper_cyc;

	// load value for a timer that must expire after n cycles
	function automatic logic [31:0] wwdsup_dec1(input logic [31:0] n);
		return (n == '0) ? '0 : n - 32'h0000_0001;
	endfunction : wwdsup_dec1

	// lower window bound for the chosen source
	function automatic logic [31:0] wwdsup_lower(
		input logic [1:0] cfg,
		input logic [31:0] cap_lo
	);
		logic [31:0] v;
		v = OP_LOWER_CYC;
		unique case (cfg)
			wwdsup_pkg::CFG_CAP: v = cap_lo;
			wwdsup_pkg::CFG_PULLUP: v = PU_LOWER_CYC;
			wwdsup_pkg::CFG_OPEN: v = OP_LOWER_CYC;
			default: v = OP_LOWER_CYC;
		endcase
		return v;
	endfunction : wwdsup_lower

	// upper window bound for the chosen source
	function automatic logic [31:0] wwdsup_upper(
		input logic [1:0] cfg,
		input logic [31:0] cap_up
	);
		logic [31:0] v;
		v = OP_UPPER_CYC;
		unique case (cfg)
			wwdsup_pkg::CFG_CAP: v = cap_up;
			wwdsup_pkg::CFG_PULLUP: v = PU_UPPER_CYC;
			wwdsup_pkg::CFG_OPEN: v = OP_UPPER_CYC;
			default: v = OP_UPPER_CYC;
		endcase
		return v;
	endfunction : wwdsup_upper

	// bounds from the timeout-config pin
	assign lower_cyc = wwdsup_lower(timeout_config_pin,
		cap_lower_cycles);
	assign upper_cyc = wwdsup_upper(timeout_config_pin,
		cap_upper_cycles);

	// reset delay timer
	wwdsup_timer u_rst_tmr (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.load(rst_load),
		.load_val(rst_val),
		.count(rst_cnt)
	);

	// watchdog window and fault-width timer
	wwdsup_timer u_wd_tmr (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.load(wd_load),
		.load_val(wd_val),
		.count(wd_cnt)
	);

	// next-state logic of supervisor and watchdog
	always_comb begin
		st_nxt = st_r;
		st_nxt.kick_prev = watchdog_kick_in;
		rst_load = 1'b0;
		rst_val = '0;
		wd_load = 1'b0;
		wd_val = '0;
		hold = !manual_reset_n || !supply_good;
		unique case (st_r.sup)
			wwdsup_pkg::SUP_HOLD: begin
				if (!hold) begin
					st_nxt.sup = wwdsup_pkg::SUP_DELAY;
					rst_load = 1'b1;
					rst_val = wwdsup_dec1(RST_CYC);
				end
			end
			wwdsup_pkg::SUP_DELAY: begin
				if (hold) begin
					st_nxt.sup = wwdsup_pkg::SUP_HOLD;
				end else if (rst_cnt == '0) begin
					st_nxt.sup = wwdsup_pkg::SUP_RUN;
				end
			end
			wwdsup_pkg::SUP_RUN: begin
				if (hold) begin
					st_nxt.sup = wwdsup_pkg::SUP_HOLD;
				end
			end
			default: st_nxt.sup = wwdsup_pkg::SUP_HOLD;
		endcase
		active = watchdog_enable_strap &&
			st_nxt.sup == wwdsup_pkg::SUP_RUN;
		// pin levels too, so a wired low also masks the kick
		kick_fall = st_r.kick_prev && !watchdog_kick_in;
		kick_ok = kick_fall && active && reset_n_i && watchdog_fault_n_i &&
			!st_r.rst_oe && !st_r.flt_oe;
		if (!active) begin
			st_nxt.wd = wwdsup_pkg::WD_IDLE;
		end else begin
			unique case (st_r.wd)
				wwdsup_pkg::WD_IDLE: begin
					st_nxt.wd = wwdsup_pkg::WD_CLOSED;
					wd_load = 1'b1;
					wd_val = wwdsup_dec1(lower_cyc);
				end
				wwdsup_pkg::WD_CLOSED: begin
					if (kick_ok) begin
						st_nxt.wd = wwdsup_pkg::WD_FAULT;
						wd_load = 1'b1;
						wd_val = wwdsup_dec1(RST_CYC);
					end else if (wd_cnt == '0) begin
						st_nxt.wd = wwdsup_pkg::WD_OPEN;
						wd_load = 1'b1;
						wd_val = wwdsup_dec1((upper_cyc > lower_cyc) ?
							upper_cyc - lower_cyc : 32'h0000_0001);
					end
				end
				wwdsup_pkg::WD_OPEN: begin
					if (kick_ok) begin
						st_nxt.wd = wwdsup_pkg::WD_CLOSED;
						wd_load = 1'b1;
						wd_val = wwdsup_dec1(lower_cyc);
					end else if (wd_cnt == '0) begin
						st_nxt.wd = wwdsup_pkg::WD_FAULT;
						wd_load = 1'b1;
						wd_val = wwdsup_dec1(RST_CYC);
					end
				end
				wwdsup_pkg::WD_FAULT: begin
					if (wd_cnt == '0) begin
						st_nxt.wd = wwdsup_pkg::WD_CLOSED;
						wd_load = 1'b1;
						wd_val = wwdsup_dec1(lower_cyc);
					end
				end
			endcase
		end
		// open-drain drives: data low, enable pulls the pin
		st_nxt.rst_o = 1'b0;
		st_nxt.flt_o = 1'b0;
		st_nxt.rst_oe = st_nxt.sup != wwdsup_pkg::SUP_RUN;
		st_nxt.flt_oe = st_nxt.wd == wwdsup_pkg::WD_FAULT;
	end

	// state register; reset asserts system reset
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r.sup <= wwdsup_pkg::SUP_HOLD;
			st_r.wd <= wwdsup_pkg::WD_IDLE;
			st_r.kick_prev <= 1'b1;
			st_r.rst_o <= 1'b0;
			st_r.rst_oe <= 1'b1;
			st_r.flt_o <= 1'b0;
			st_r.flt_oe <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign reset_n_o = st_r.rst_o;
	assign reset_n_oe = st_r.rst_oe;
	assign watchdog_fault_n_o = st_r.flt_o;
	assign watchdog_fault_n_oe = st_r.flt_oe;

	// helper counters read only by assertions
	logic [31:0] clean_len_r;
	logic [31:0] fault_len_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			clean_len_r <= '0;
			fault_len_r <= '0;
		end else begin
			if (hold) begin
				clean_len_r <= '0;
			end else if (clean_len_r != 32'hFFFF_FFFF) begin
				clean_len_r <= clean_len_r + 32'h0000_0001;
			end
			fault_len_r <= st_r.flt_oe ? fault_len_r + 32'h0000_0001 : '0;
		end
	end

	// manual reset low pulls reset next cycle
	a_manual_reset_low: assert property (@(posedge sys_clk)
		disable iff (sys_rst) !manual_reset_n |=> reset_n_oe)
		else $error("manual reset low did not assert reset");

	// supply loss pulls reset next cycle
	a_supply_loss_reset: assert property (@(posedge sys_clk)
		disable iff (sys_rst) !supply_good |=> reset_n_oe)
		else $error("supply loss did not assert reset");

	// reset released only after a clean delay
	a_release_after_delay: assert property (@(posedge sys_clk)
		disable iff (sys_rst) $fell(reset_n_oe) |-> clean_len_r >= RST_CYC)
		else $error("reset released before the delay ran out");

	// release needs both supply and manual input good
	a_release_needs_both: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		$fell(reset_n_oe) |-> $past(supply_good) && $past(manual_reset_n))
		else $error("reset released while a hold cause stood");

	// delay restarts when supply returns
	a_delay_starts: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		st_r.sup == wwdsup_pkg::SUP_HOLD && !hold |=>
		st_r.sup == wwdsup_pkg::SUP_DELAY && rst_cnt == wwdsup_dec1(RST_CYC))
		else $error("reset delay did not start");

	// disabled watchdog never faults
	a_strap_disables: assert property (@(posedge sys_clk)
		disable iff (sys_rst) !watchdog_enable_strap |=> !watchdog_fault_n_oe)
		else $error("fault driven while watchdog disabled");

	// fault never together with reset
	a_fault_needs_run: assert property (@(posedge sys_clk)
		disable iff (sys_rst) watchdog_fault_n_oe |-> !reset_n_oe)
		else $error("fault driven while reset asserted");

	// early kick faults next cycle
	a_early_kick_fault: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		st_r.wd == wwdsup_pkg::WD_CLOSED && kick_ok && active |=>
		watchdog_fault_n_oe)
		else $error("early kick did not raise a fault");

	// missed window faults next cycle
	a_late_kick_fault: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		st_r.wd == wwdsup_pkg::WD_OPEN && wd_cnt == '0 && !kick_ok &&
		active |=> watchdog_fault_n_oe)
		else $error("missed window did not raise a fault");

	// kick in window restarts the closed phase
	a_window_restart: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		st_r.wd == wwdsup_pkg::WD_OPEN && kick_ok && active |=>
		st_r.wd == wwdsup_pkg::WD_CLOSED && wd_cnt == wwdsup_dec1(lower_cyc))
		else $error("window did not restart after kick");

	// kick while fault pin low is ignored
	a_kick_masked: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		!watchdog_fault_n_i && !st_r.flt_oe &&
		st_r.wd == wwdsup_pkg::WD_CLOSED && wd_cnt != '0 |=>
		!watchdog_fault_n_oe)
		else $error("kick taken while fault pin low");

	// an undisturbed fault lasts the reset delay
	a_fault_width: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		$fell(watchdog_fault_n_oe) && $past(watchdog_enable_strap) &&
		!reset_n_oe |-> fault_len_r == RST_CYC)
		else $error("fault width differs from reset delay");

endmodule : wwdsup_top

// ===== testbench/wwdsup_host.sv
// host model that services the watchdog kick input
`timescale 1ns/1ps

module wwdsup_host (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic kick_req,
	input wire logic [7:0] kick_delay,
	output logic watchdog_kick_in
);
	logic busy_r;
	logic [7:0] cnt_r;

	// wait the asked delay, then one low cycle makes the falling edge
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			watchdog_kick_in <= 1'b1;
			busy_r <= 1'b0;
			cnt_r <= 8'h00;
		end else if (kick_req) begin
			watchdog_kick_in <= 1'b1;
			busy_r <= 1'b1;
			cnt_r <= kick_delay;
		end else if (busy_r && cnt_r == 8'h00) begin
			watchdog_kick_in <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			watchdog_kick_in <= 1'b1;
			cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule : wwdsup_host

// ===== testbench/wwdsup_tb_top.sv
// self-checking bench for the window watchdog supervisor
`timescale 1ns/1ps

module wwdsup_tb_top;
	localparam logic [31:0] RST = 32'h14;
	logic sys_clk, sys_rst, supply_good, manual_reset_n, kick, strap;
	logic [1:0] cfg;
	logic [31:0] cap_lo, cap_up;
	logic rst_o, rst_oe, flt_o, flt_oe, kick_req, flt_ext;
	logic [7:0] kick_delay;
	int n_errors, compares, cyc, fw, last_w, faults;

	// device under test, open-drain wires pulled up, flt_ext pulls fault low
	wwdsup_top #(.RST_CYC(RST), .PU_LOWER_CYC(32'h5), .PU_UPPER_CYC(32'h1E),
		.OP_LOWER_CYC(32'h8), .OP_UPPER_CYC(32'h28)) wwdsup_top_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .supply_good(supply_good),
		.manual_reset_n(manual_reset_n), .watchdog_kick_in(kick),
		.watchdog_enable_strap(strap), .timeout_config_pin(cfg),
		.cap_lower_cycles(cap_lo), .cap_upper_cycles(cap_up),
		.reset_n_i(rst_oe ? rst_o : 1'b1), .reset_n_o(rst_o),
		.reset_n_oe(rst_oe),
		.watchdog_fault_n_i(!flt_ext && (flt_oe ? flt_o : 1'b1)),
		.watchdog_fault_n_o(flt_o),
		.watchdog_fault_n_oe(flt_oe));

	// host servicing the kick input
	wwdsup_host wwdsup_host_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.kick_req(kick_req), .kick_delay(kick_delay),
		.watchdog_kick_in(kick));

	// clock at 25 MHz
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// cycle ceiling and fault pulse monitor
	always @(posedge sys_clk) begin
		cyc++;
		if (flt_oe === 1'b1) begin
			if (fw == 0) faults++;
			fw++;
		end else if (fw != 0) begin
			last_w = fw;
			fw = 0;
		end
		if (cyc == 5000) begin
			n_errors++;
			$display("BAD %0t timeout", $time);
			complete_run();
		end
	end

	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk

	task automatic st(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			#1;
		end
	endtask : st

	task automatic wait_rel(input string msg);
		int n;
		n = 0;
		do begin
			st(1);
			n++;
		end while (rst_oe === 1'b1 && n < 200);
		chk(n == RST + 1, msg);
	endtask : wait_rel

	task automatic rel();
		manual_reset_n = 1'b0;
		st(2);
		chk(rst_oe === 1'b1, "manual reset not asserted");
		chk(rst_o === 1'b0, "reset drive data not low");
		chk(flt_oe === 1'b0, "fault driven in reset");
		manual_reset_n = 1'b1;
		wait_rel("manual release delay wrong");
	endtask : rel

	task automatic kick_at(input int d);
		kick_req = 1'b1;
		kick_delay = 8'(d);
		st(1);
		kick_req = 1'b0;
		st(d + 2);
	endtask : kick_at

	task automatic sup_test();
		rel();
		supply_good = 1'b0;
		st(2);
		chk(rst_oe === 1'b1, "undervoltage not asserting reset");
		supply_good = 1'b1;
		st(5);
		supply_good = 1'b0;
		st(1);
		supply_good = 1'b1;
		wait_rel("supply release delay wrong");
	endtask : sup_test

	task automatic win_test(input logic [1:0] c, input int lo, input int up);
		int f0;
		cfg = c;
		rel();
		f0 = faults;
		repeat (3) kick_at((lo + up) / 2 - 3);
		chk(faults == f0 && flt_oe === 1'b0, "fault after good kick");
		st(up - 1);
		chk(flt_oe === 1'b0, "fault before upper bound");
		st(3);
		chk(flt_oe === 1'b1, "no fault at upper bound");
		chk(flt_o === 1'b0, "fault drive data not low");
		st(RST);
		chk(last_w == RST, "fault width wrong");
	endtask : win_test

	task automatic early_test();
		int f0;
		cfg = 2'h0;
		rel();
		// another device holds the fault wire low: the kick is ignored
		flt_ext = 1'b1;
		kick_at(0);
		chk(flt_oe === 1'b0, "kick taken with fault wire low");
		flt_ext = 1'b0;
		kick_at(2);
		st(2);
		chk(flt_oe === 1'b1, "early kick not flagged");
		kick_at(0);
		st(RST);
		chk(last_w == RST, "kick during fault changed it");
		f0 = faults;
		kick_at(12);
		st(5);
		chk(faults == f0, "window not restarted after fault");
		kick_at(0);
		st(3);
		manual_reset_n = 1'b0;
		st(2);
		chk(flt_oe === 1'b0, "fault kept during reset");
	endtask : early_test

	task automatic strap_test();
		int f0;
		strap = 1'b0;
		rel();
		f0 = faults;
		kick_at(0);
		st(60);
		chk(faults == f0, "fault while disabled");
		strap = 1'b1;
	endtask : strap_test

	task automatic complete_run();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	// main sequence
	initial begin
		sys_rst = 1'b1;
		supply_good = 1'b1;
		manual_reset_n = 1'b1;
		strap = 1'b1;
		cfg = 2'h0;
		cap_lo = 32'hA;
		cap_up = 32'h1E;
		kick_req = 1'b0;
		kick_delay = 8'h00;
		flt_ext = 1'b0;
		st(5);
		sys_rst = 1'b0;
		st(1);
		sup_test();
		win_test(2'h0, 10, 30);
		win_test(2'h1, 5, 30);
		win_test(2'h2, 8, 40);
		win_test(2'h3, 8, 40);
		early_test();
		strap_test();
		complete_run();
	end
endmodule : wwdsup_tb_top
